// ---- inc/sdc_pkg.sv ----
package sdc_pkg;

    // Serial word layout
    localparam int          WORD_W        = 24;
    localparam int          ADDR_W        = 4;
    localparam int          ADDR_LSB      = 0;

    // Register address codes on the four low bits
    localparam logic [3:0]  ADDR_RF_CFG   = 4'h3;  // RF config word
    localparam logic [3:0]  ADDR_IF_CFG   = 4'h5;  // IF word
    localparam logic [3:0]  ADDR_AUTO     = 4'h9;  // Word holding auto_powerup
    localparam int          ADDR_N_BIT    = 0;     // Low bit 0 selects the divide word

    // Divide word fields
    localparam int          RF_N_LSB      = 13;
    localparam int          RF_N_W        = 11;
    localparam int          RF_A_W        = 2;
    localparam int          RF_B_W        = 2;
    localparam int          RF_C_W        = 7;
    localparam int          RF_B_LSB      = 2;
    localparam int          RF_C_LSB      = 4;

    // RF config word fields
    localparam int          RF_POWER_DOWN_BIT     = 23;
    localparam int          RF_P_BIT      = 22;
    localparam int          RF_R_LSB      = 16;
    localparam int          RF_R_W        = 6;
    localparam int          RF_FRACTION_DENOMINATOR_LSB     = 4;
    localparam int          RF_FRACTION_DENOMINATOR_W       = 12;

    // IF word fields
    localparam int          IF_POWER_DOWN_BIT     = 23;
    localparam int          IF_N_LSB      = 4;
    localparam int          IF_N_W        = 19;
    localparam int          IF_A_W        = 3;
    localparam int          IF_B_W        = 16;

    // Auto powerup position in its word
    localparam int          AUTO_BIT      = 23;

    // Prescaler base moduli
    localparam logic [4:0]  RF_MOD_SMALL  = 5'h08;  // 8/9/12/13 set
    localparam logic [4:0]  RF_MOD_LARGE  = 5'h10;  // 16/17/20/21 set

    // Values after reset
    localparam logic                RST_RF_POWER_DOWN   = 1'b1;
    localparam logic                RST_RF_P    = 1'b0;
    localparam logic [RF_R_W-1:0]   RST_RF_R    = 6'h01;
    localparam logic [RF_FRACTION_DENOMINATOR_W-1:0]  RST_RF_FRACTION_DENOMINATOR   = 12'h000;
    localparam logic                RST_IF_POWER_DOWN   = 1'b1;
    localparam logic [IF_N_W-1:0]   RST_IF_N    = 19'h00000;
    localparam logic [RF_N_W-1:0]   RST_RF_N    = 11'h000;
    localparam logic                RST_AUTO    = 1'b0;

endpackage : sdc_pkg

// ---- logic/sdc_rdiv.sv ----
`timescale 1ns/10ps

// Reference divider: one output pulse per div_value input ticks
module sdc_rdiv (
    input  wire logic                          core_clk,   // Core clock
    input  wire logic                          sys_rst,    // Synchronous reset
    input  wire logic                          ref_tick,   // One-cycle reference edge
    input  wire logic [sdc_pkg::RF_R_W-1:0]    div_value,  // Divide ratio 1..63
    output logic                               div_pulse   // One-cycle divided tick
);

    logic [sdc_pkg::RF_R_W-1:0] count_reg;   // Ticks seen in this period
    logic [sdc_pkg::RF_R_W-1:0] count_next;
    logic                       pulse_reg;
    logic                       pulse_next;
    logic [sdc_pkg::RF_R_W-1:0] last_count;  // Count at which the period ends

    ////////////////////////////////////////////////////////////////////////////
    // Next state: a ratio of zero is illegal and behaves as one
    always_comb begin
        last_count = (div_value == '0) ? '0 : div_value - 6'h01;
        count_next = count_reg;
        pulse_next = 1'b0;
        if (ref_tick) begin
            if (count_reg >= last_count) begin  // Period done, also after a ratio cut
                count_next = '0;
                pulse_next = 1'b1;
            end else begin
                count_next = count_reg + 6'h01;
            end
        end
    end

    // Registers only
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count_reg <= '0;
            pulse_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            pulse_reg <= pulse_next;
        end
    end

    assign div_pulse = pulse_reg;

endmodule : sdc_rdiv

// ---- logic/sdc_regs.sv ----
// Operation
// - RF word: power-down, prescaler, R divide, denominator
// - Reference divider divides exactly by 1 to 63
// - Prescaler select picks small or large modulus set
// - RF power-down stops PLL, tristates charge pump
// - Chip enable low always powers RF down
// - Auto powerup plus divide write overrides RF power-down bit
// - Otherwise RF power-down bit decides
// - IF word: power-down bit, 19-bit divide split
// - Feedback divide equals P*C plus 4B plus A; the fixed split gives 16C plus 4B plus A, so only the large set matches
// - 24-bit words MSB first, committed on strobe rise
// - IF power-down stops IF PLL, tristates pump
// - Auto powerup plus divide write clears IF power-down
`timescale 1ns/10ps

module sdc_regs (
    input  wire logic                          core_clk,                // Core clock, 50 MHz
    input  wire logic                          sys_rst,                 // Synchronous reset, high
    input  wire logic                          serial_clk,              // Link shift clock
    input  wire logic                          serial_data,             // Link data, MSB first
    input  wire logic                          latch_strobe,            // Commit strobe pin
    input  wire logic                          chip_enable,             // Chip enable pin
    input  wire logic                          ref_in,                  // Reference input pin
    output logic                               rf_pll_enable,           // RF PLL powered
    output logic                               rf_cp_tristate,          // RF pump high-Z
    output logic                               if_pll_enable,           // IF PLL powered
    output logic                               if_cp_tristate,          // IF pump high-Z
    output logic                               rf_prescaler_select,     // Prescaler set
    output logic [4:0]                         rf_prescaler_modulus,    // 8 or 16 base
    output logic [sdc_pkg::RF_R_W-1:0]         rf_reference_divide,     // R ratio
    output logic [sdc_pkg::RF_FRACTION_DENOMINATOR_W-1:0]        rf_fraction_denominator, // Denominator
    output logic [sdc_pkg::RF_N_W-1:0]         rf_feedback_divide,      // Combined N
    output logic [sdc_pkg::RF_C_W-1:0]         rf_main_count,           // C count
    output logic [sdc_pkg::RF_B_W-1:0]         rf_secondary_count,      // B count
    output logic [sdc_pkg::RF_A_W-1:0]         rf_swallow_count,        // A count
    output logic [sdc_pkg::IF_B_W-1:0]         if_main_count,           // IF main count
    output logic [sdc_pkg::IF_A_W-1:0]         if_swallow_count,        // IF swallow count
    output logic                               auto_powerup,            // Auto powerup bit
    output logic                               rf_ref_pulse             // Divided reference
);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: shift register on the serial clock

    logic [sdc_pkg::WORD_W-1:0] shift_reg;   // Never reset; only read after a frame
    logic [sdc_pkg::WORD_W-1:0] shift_next;

    // New bit enters at the bottom so the first bit ends at the top
    always_comb begin
        shift_next = {shift_reg[sdc_pkg::WORD_W-2:0], serial_data};
    end

    always_ff @(posedge serial_clk) begin
        shift_reg <= shift_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: strobe, chip enable, reference

    logic [2:0] sync1_reg;    // First stage, read by stage two only
    logic [2:0] sync2_reg;    // Second stage, safe to use
    logic [2:0] sync_next;
    logic       le_prev_reg;  // Delayed strobe for edge detect
    logic       le_prev_next;
    logic       ref_prev_reg; // Delayed reference for edge detect
    logic       ref_prev_next;

    always_comb begin
        sync_next     = {ref_in, chip_enable, latch_strobe};
        le_prev_next  = sync2_reg[0];
        ref_prev_next = sync2_reg[2];
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_reg    <= 3'h0;
            sync2_reg    <= 3'h0;
            le_prev_reg  <= 1'b0;
            ref_prev_reg <= 1'b0;
        end else begin
            sync1_reg    <= sync_next;
            sync2_reg    <= sync1_reg;
            le_prev_reg  <= le_prev_next;
            ref_prev_reg <= ref_prev_next;
        end
    end

    logic commit;    // High for one cycle on a synced strobe rise
    logic ce_level;  // Synced chip enable
    logic ref_tick;  // Synced reference rise
    assign commit   = sync2_reg[0] & ~le_prev_reg;
    assign ce_level = sync2_reg[1];
    assign ref_tick = sync2_reg[2] & ~ref_prev_reg;

    // The host stops the serial clock before raising the strobe, so the
    // shift word is static while it is copied; this is the word crossing.
    logic [sdc_pkg::ADDR_W-1:0] word_addr;
    assign word_addr = shift_reg[sdc_pkg::ADDR_LSB +: sdc_pkg::ADDR_W];

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: configuration registers

    logic                        rf_power_down_reg,   rf_power_down_next;
    logic                        rf_p_reg,    rf_p_next;
    logic [sdc_pkg::RF_R_W-1:0]  rf_r_reg,    rf_r_next;
    logic [sdc_pkg::RF_FRACTION_DENOMINATOR_W-1:0] rf_fraction_denominator_reg,   rf_fraction_denominator_next;
    logic                        if_power_down_reg,   if_power_down_next;
    logic [sdc_pkg::IF_N_W-1:0]  if_n_reg,    if_n_next;
    logic [sdc_pkg::RF_N_W-1:0]  rf_n_reg,    rf_n_next;
    logic                        auto_reg,    auto_next;
    logic                        force_reg,   force_next;  // Auto powerup holds RF on

    // Decode and load the registers the address selects; a divide write under auto powerup also clears IF power-down
    always_comb begin
        rf_power_down_next = rf_power_down_reg;
        rf_p_next  = rf_p_reg;
        rf_r_next  = rf_r_reg;
        rf_fraction_denominator_next = rf_fraction_denominator_reg;
        if_power_down_next = if_power_down_reg;
        if_n_next  = if_n_reg;
        rf_n_next  = rf_n_reg;
        auto_next  = auto_reg;
        force_next = force_reg;
        if (commit) begin
            if (!word_addr[sdc_pkg::ADDR_N_BIT]) begin
                // Divide word; numerator bits are not kept here
                rf_n_next = shift_reg[sdc_pkg::RF_N_LSB +: sdc_pkg::RF_N_W];
                if (auto_reg) begin
                    if_power_down_next = 1'b0;
                    force_next = 1'b1;
                end
            end else begin
                case (word_addr)
                    sdc_pkg::ADDR_RF_CFG: begin
                        rf_power_down_next = shift_reg[sdc_pkg::RF_POWER_DOWN_BIT];
                        rf_p_next  = shift_reg[sdc_pkg::RF_P_BIT];
                        rf_r_next  = shift_reg[sdc_pkg::RF_R_LSB +: sdc_pkg::RF_R_W];
                        rf_fraction_denominator_next = shift_reg[sdc_pkg::RF_FRACTION_DENOMINATOR_LSB +: sdc_pkg::RF_FRACTION_DENOMINATOR_W];
                        force_next = 1'b0;  // Power-down bit takes control again
                    end
                    sdc_pkg::ADDR_IF_CFG: begin
                        if_power_down_next = shift_reg[sdc_pkg::IF_POWER_DOWN_BIT];
                        if_n_next  = shift_reg[sdc_pkg::IF_N_LSB +: sdc_pkg::IF_N_W];
                    end
                    sdc_pkg::ADDR_AUTO: begin
                        auto_next = shift_reg[sdc_pkg::AUTO_BIT];
                        if (!shift_reg[sdc_pkg::AUTO_BIT]) begin
                            force_next = 1'b0;
                        end
                    end
                    default: begin
                        // Other words belong to blocks not held here
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rf_power_down_reg <= sdc_pkg::RST_RF_POWER_DOWN;
            rf_p_reg  <= sdc_pkg::RST_RF_P;
            rf_r_reg  <= sdc_pkg::RST_RF_R;
            rf_fraction_denominator_reg <= sdc_pkg::RST_RF_FRACTION_DENOMINATOR;
            if_power_down_reg <= sdc_pkg::RST_IF_POWER_DOWN;
            if_n_reg  <= sdc_pkg::RST_IF_N;
            rf_n_reg  <= sdc_pkg::RST_RF_N;
            auto_reg  <= sdc_pkg::RST_AUTO;
            force_reg <= 1'b0;
        end else begin
            rf_power_down_reg <= rf_power_down_next;
            rf_p_reg  <= rf_p_next;
            rf_r_reg  <= rf_r_next;
            rf_fraction_denominator_reg <= rf_fraction_denominator_next;
            if_power_down_reg <= if_power_down_next;
            if_n_reg  <= if_n_next;
            rf_n_reg  <= rf_n_next;
            auto_reg  <= auto_next;
            force_reg <= force_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power control and derived counts, all registered for clean outputs

    logic                        rf_on_reg,  rf_on_next;
    logic                        if_on_reg,  if_on_next;
    logic [4:0]                  mod_reg,    mod_next;
    logic [sdc_pkg::RF_C_W-1:0]  c_reg,      c_next;
    logic [sdc_pkg::RF_B_W-1:0]  b_reg,      b_next;
    logic [sdc_pkg::RF_A_W-1:0]  a_reg,      a_next;
    logic [sdc_pkg::IF_B_W-1:0]  ifb_reg,    ifb_next;
    logic [sdc_pkg::IF_A_W-1:0]  ifa_reg,    ifa_next;

    // Precedence: chip enable, then auto powerup, then the bit itself
    always_comb begin
        if (!ce_level) begin
            rf_on_next = 1'b0;
        end else if (force_reg) begin
            rf_on_next = 1'b1;
        end else begin
            rf_on_next = ~rf_power_down_reg;
        end
        if_on_next = ce_level & ~if_power_down_reg;
        // Prescaler set base; the fixed split gives N = 16*C + 4*B + A, equal to base*C + 4*B + A only for the large set
        mod_next = rf_p_reg ? sdc_pkg::RF_MOD_LARGE : sdc_pkg::RF_MOD_SMALL;
        c_next   = rf_n_reg[sdc_pkg::RF_C_LSB +: sdc_pkg::RF_C_W];
        b_next   = rf_n_reg[sdc_pkg::RF_B_LSB +: sdc_pkg::RF_B_W];
        a_next   = rf_n_reg[0 +: sdc_pkg::RF_A_W];
        // IF split for the 8/9 prescaler; legal range is the host's duty
        ifb_next = if_n_reg[sdc_pkg::IF_A_W +: sdc_pkg::IF_B_W];
        ifa_next = if_n_reg[0 +: sdc_pkg::IF_A_W];
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rf_on_reg <= 1'b0;
            if_on_reg <= 1'b0;
            mod_reg   <= sdc_pkg::RF_MOD_SMALL;
            c_reg     <= '0;
            b_reg     <= '0;
            a_reg     <= '0;
            ifb_reg   <= '0;
            ifa_reg   <= '0;
        end else begin
            rf_on_reg <= rf_on_next;
            if_on_reg <= if_on_next;
            mod_reg   <= mod_next;
            c_reg     <= c_next;
            b_reg     <= b_next;
            a_reg     <= a_next;
            ifb_reg   <= ifb_next;
            ifa_reg   <= ifa_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference divider on the synced reference edges

    sdc_rdiv u_rdiv (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .ref_tick  (ref_tick),
        .div_value (rf_r_reg),
        .div_pulse (rf_ref_pulse)
    );

    // Output drive, all from flip-flops
    assign rf_pll_enable           = rf_on_reg;
    assign rf_cp_tristate          = ~rf_on_reg;
    assign if_pll_enable           = if_on_reg;
    assign if_cp_tristate          = ~if_on_reg;
    assign rf_prescaler_select     = rf_p_reg;
    assign rf_prescaler_modulus    = mod_reg;
    assign rf_reference_divide     = rf_r_reg;
    assign rf_fraction_denominator = rf_fraction_denominator_reg;
    assign rf_feedback_divide      = rf_n_reg;
    assign rf_main_count           = c_reg;
    assign rf_secondary_count      = b_reg;
    assign rf_swallow_count        = a_reg;
    assign if_main_count           = ifb_reg;
    assign if_swallow_count        = ifa_reg;
    assign auto_powerup            = auto_reg;

endmodule : sdc_regs

// ---- bench/sdc_regs_properties.sv ----
`timescale 1ns/10ps
// Port watcher; every check runs on core_clk and is muted during sys_rst
module sdc_regs_properties (
    input wire logic        core_clk,                // Core clock
    input wire logic        sys_rst,                 // Synchronous reset
    input wire logic        latch_strobe,            // Commit strobe pin
    input wire logic        chip_enable,             // Chip enable pin
    input wire logic        rf_pll_enable,           // RF PLL powered
    input wire logic        rf_cp_tristate,          // RF pump high-Z
    input wire logic        if_pll_enable,           // IF PLL powered
    input wire logic        if_cp_tristate,          // IF pump high-Z
    input wire logic        rf_prescaler_select,     // Prescaler set
    input wire logic [4:0]  rf_prescaler_modulus,    // Base modulus
    input wire logic [5:0]  rf_reference_divide,     // R ratio
    input wire logic [11:0] rf_fraction_denominator, // Denominator
    input wire logic [10:0] rf_feedback_divide,      // Combined N
    input wire logic [6:0]  rf_main_count,           // C count
    input wire logic [1:0]  rf_secondary_count,      // B count
    input wire logic [1:0]  rf_swallow_count,        // A count
    input wire logic [15:0] if_main_count,           // IF main count
    input wire logic [2:0]  if_swallow_count,        // IF swallow count
    input wire logic        rf_ref_pulse             // Divided reference
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    // Pumps are high-Z exactly while their PLL is off
    rf_pump_hiz_a: assert property (rf_cp_tristate == !rf_pll_enable)
        else $error("RF pump state does not mirror power");
    if_pump_hiz_a: assert property (if_cp_tristate == !if_pll_enable)
        else $error("IF pump state does not mirror power");
    // Modulus lags select by one edge, so only judge a settled select
    modulus_select_a: assert property ($stable(rf_prescaler_select) |->
        rf_prescaler_modulus == (rf_prescaler_select ? 5'h10 : 5'h08))
        else $error("Modulus does not follow prescaler select");
    count_split_a: assert property ($stable(rf_feedback_divide) |->
        {rf_main_count, rf_secondary_count, rf_swallow_count} == rf_feedback_divide)
        else $error("Counts do not split the feedback divide");
    // Two sync stages and the power register take three edges; five low samples leave margin
    ce_power_off_a: assert property ((!chip_enable)[*5] |->
        !rf_pll_enable && !if_pll_enable)
        else $error("PLL powered while chip enable low");
    // Stored fields move only a few edges after a strobe
    rf_commit_only_a: assert property (($changed(rf_reference_divide) ||
        $changed(rf_fraction_denominator) || $changed(rf_feedback_divide))
        |-> $past(latch_strobe, 2) || $past(latch_strobe, 3))
        else $error("RF field changed without a commit");
    if_commit_only_a: assert property (($changed(if_main_count) ||
        $changed(if_swallow_count)) |-> $past(latch_strobe, 2) || $past(latch_strobe, 3))
        else $error("IF field changed without a commit");
    ref_pulse_once_a: assert property (rf_ref_pulse |=> !rf_ref_pulse)
        else $error("Reference pulse longer than one cycle");
    cover property (rf_pll_enable && rf_prescaler_modulus == 5'h10);
    cover property ($rose(if_pll_enable));
    cover property (rf_ref_pulse);
endmodule : sdc_regs_properties

bind sdc_regs sdc_regs_properties u_props (.core_clk, .sys_rst, .latch_strobe, .chip_enable,
    .rf_pll_enable, .rf_cp_tristate, .if_pll_enable, .if_cp_tristate, .rf_prescaler_select,
    .rf_prescaler_modulus, .rf_reference_divide, .rf_fraction_denominator, .rf_feedback_divide,
    .rf_main_count, .rf_secondary_count, .rf_swallow_count, .if_main_count, .if_swallow_count,
    .rf_ref_pulse);

// ---- bench/sdc_host_model.sv ----
`timescale 1ns/10ps
// Host end of the three-wire link: one 24-bit word per go pulse, then a strobe
module sdc_host_model (
    input  wire logic        go,           // Start one frame
    input  wire logic [23:0] word,         // Word to send
    output logic             serial_clk,   // Link clock, still outside frames
    output logic             serial_data,  // Link data
    output logic             latch_strobe, // Commit strobe
    output logic             busy          // Frame in progress
);
    int i;  // Bit index
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_strobe = 1'b0;
        busy = 1'b0;
    end
    // Odd start offset keeps the 125 ns link clock off the core clock phase
    always @(posedge go) begin
        busy = 1'b1;
        #7.3;
        for (i = 23; i >= 0; i--) begin  // MSB first, 24 bits
            serial_data = word[i];
            #62.5 serial_clk = 1'b1;
            #62.5 serial_clk = 1'b0;
        end
        // Clock stopped and data held well past the 5-cycle window
        #62.5 latch_strobe = 1'b1;
        #250 latch_strobe = 1'b0;
        serial_data = ~word[0];  // Released line must not show a stale bit
        #250 busy = 1'b0;
    end
endmodule : sdc_host_model

// ---- bench/sdc_regs_tb.sv ----
`timescale 1ns/10ps
module sdc_regs_tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic chip_enable = 1'b1;
    logic ref_in = 1'b0;
    logic host_go = 1'b0;
    logic [23:0] host_word = 24'h000000;
    logic serial_clk, serial_data, latch_strobe, host_busy;
    logic rf_pll_enable, rf_cp_tristate, if_pll_enable, if_cp_tristate, rf_prescaler_select;
    logic auto_powerup, rf_ref_pulse;
    logic [4:0] rf_prescaler_modulus;
    logic [5:0] rf_reference_divide;
    logic [11:0] rf_fraction_denominator;
    logic [10:0] rf_feedback_divide;
    logic [6:0] rf_main_count;
    logic [1:0] rf_secondary_count, rf_swallow_count;
    logic [15:0] if_main_count;
    logic [2:0] if_swallow_count;
    logic [3:0] bad[4] = '{4'h7, 4'hb, 4'hd, 4'hf};  // Unmapped addresses
    logic [5:0] rv[3] = '{6'h01, 6'h05, 6'h3f};      // Divide ratios to try
    int n_mismatch = 0;
    int checks_done = 0;

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    sdc_regs dut (.core_clk, .sys_rst, .serial_clk, .serial_data, .latch_strobe, .chip_enable,
        .ref_in, .rf_pll_enable, .rf_cp_tristate, .if_pll_enable, .if_cp_tristate,
        .rf_prescaler_select, .rf_prescaler_modulus, .rf_reference_divide,
        .rf_fraction_denominator, .rf_feedback_divide, .rf_main_count, .rf_secondary_count,
        .rf_swallow_count, .if_main_count, .if_swallow_count, .auto_powerup, .rf_ref_pulse);

    sdc_host_model host (.go(host_go), .word(host_word), .serial_clk, .serial_data,
        .latch_strobe, .busy(host_busy));
    ////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // One frame, then room for the commit and derived outputs to settle
    task send(input logic [23:0] w);
        int i;
        @(negedge core_clk);
        host_word = w;
        host_go = 1'b1;
        @(negedge core_clk);
        host_go = 1'b0;
        for (i = 0; i < 400 && host_busy === 1'b1; i++) @(negedge core_clk);
        // A frame that never ends is a failure, not a silent skip
        if (host_busy !== 1'b0) begin
            n_mismatch++;
            $display("Error at %0t: host frame did not end", $time);
        end
        repeat (8) @(negedge core_clk);
    endtask : send

    // Steady reference, 8 cycles a period; any 2R rises hold exactly 2 pulses
    task ref_run(input logic [5:0] r);
        int k, pulses;
        pulses = 0;
        for (k = 0; k < 32 * r; k++) begin
            @(negedge core_clk);
            ref_in = (k % 8) < 4;
            if (k >= 16 * r && rf_ref_pulse === 1'b1) pulses++;
        end
        check(pulses, 32'h2);
    endtask : ref_run

    task end_test(input string name);
        $display("Test %s done, %0d mismatches so far", name, n_mismatch);
    endtask : end_test

    task report_and_stop;
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // Tests need about 5000 cycles; allow more than three times that
    initial begin
        #400us;
        n_mismatch++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge core_clk);
        check(rf_pll_enable, 1'b0);
        check(if_pll_enable, 1'b0);
        check(rf_reference_divide, sdc_pkg::RST_RF_R);
        check(rf_prescaler_modulus, sdc_pkg::RF_MOD_SMALL);
        check(auto_powerup, 1'b0);
        end_test("reset");
        send({1'b0, 1'b1, 6'h2a, 12'habc, sdc_pkg::ADDR_RF_CFG});
        check(rf_prescaler_modulus, sdc_pkg::RF_MOD_LARGE);
        check(rf_prescaler_select, 1'b1);
        check(rf_reference_divide, 6'h2a);
        check(rf_fraction_denominator, 12'habc);
        check(rf_pll_enable, 1'b1);
        send({1'b1, 1'b1, 6'h2a, 12'habc, sdc_pkg::ADDR_RF_CFG});
        check(rf_cp_tristate, 1'b1);
        end_test("rf_word");
        // Top of the any-order range for the large prescaler
        send({11'h7f7, 12'h5a5, 1'b0});
        check(rf_feedback_divide, 11'h7f7);
        check({rf_main_count, rf_secondary_count, rf_swallow_count}, 11'h7f7);
        check(32'h0 + rf_prescaler_modulus * rf_main_count + 32'h4 * rf_secondary_count
              + rf_swallow_count, 32'h7f7);
        check(rf_pll_enable, 1'b0);
        check(rf_reference_divide, 6'h2a);
        end_test("divide");
        send({1'b0, 19'h3ffff, sdc_pkg::ADDR_IF_CFG});
        check(if_cp_tristate, 1'b0);
        check({if_main_count, if_swallow_count}, 19'h3ffff);
        check(rf_feedback_divide, 11'h7f7);
        foreach (bad[i]) begin
            send({20'hfffff, bad[i]});
            check({if_pll_enable, if_main_count, rf_reference_divide},
                  {1'b1, 16'h7fff, 6'h2a});
        end
        end_test("if_word");
        send({1'b1, 19'h3ffff, sdc_pkg::ADDR_IF_CFG});
        check(if_pll_enable, 1'b0);
        send({1'b1, 19'h00000, sdc_pkg::ADDR_AUTO});
        check(auto_powerup, 1'b1);
        send({11'h037, 12'h000, 1'b0});
        check({rf_main_count, rf_secondary_count, rf_swallow_count}, 11'h037);
        check(rf_pll_enable, 1'b1);
        check(if_pll_enable, 1'b1);
        chip_enable = 1'b0;
        repeat (6) @(negedge core_clk);
        check({rf_pll_enable, if_pll_enable}, 2'h0);
        chip_enable = 1'b1;
        repeat (6) @(negedge core_clk);
        check(rf_pll_enable, 1'b1);
        end_test("auto");
        // Reset in mid-run, held three edges so no stored field moves after release
        sys_rst = 1'b1;
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge core_clk);
        check({rf_pll_enable, auto_powerup, if_pll_enable}, 3'h0);
        check(rf_feedback_divide, sdc_pkg::RST_RF_N);
        end_test("mid_reset");
        foreach (rv[i]) begin
            send({1'b0, 1'b0, rv[i], 12'h123, sdc_pkg::ADDR_RF_CFG});
            check(rf_reference_divide, rv[i]);
            ref_run(rv[i]);
        end
        end_test("ref_divider");
        report_and_stop();
    end
endmodule : sdc_regs_tb
